// ==== fepcs_line_coder.sv ====
// 100 Mb/s transmit coding path and receive line decoding of one port.
`timescale 1ns/10ps

// Notes on behaviour
// - Each MAC nibble becomes a 5-bit code-group.
// - First two preamble nibbles become J then K.
// - Later preamble and data nibbles sent as data.
// - Transmit enable low appends T then R.
// - IDLE fill continues until transmit enable returns.
// - Scrambler is an 11-bit closed-loop LFSR.
// - Each NRZ bit XORed with scrambler output.
// - Seed comes from upper four address straps.
// - Scrambled stream converted NRZ to NRZI.
// - Every second one drives an output, alternating between the two.
// - Drive outputs are MLT-3 only; binary NRZI is on tx_nrzi_o.
// - Receive path turns MLT-3 into parallel data.
// - Link pulses never raise 100 Mb/s signal detect.
// - Three-level receive symbols decoded to NRZI.
// - Receive NRZI converted back to NRZ.
// - Received bits grouped into 5-bit symbols.
// - IDLE code-group is 11111.
// - Scrambler can be bypassed.
module fepcs_line_coder #(
    parameter int BIT_DIV = 1
) (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [4:0] phy_address_straps_i,
    input  wire logic       scramble_bypass_i,
    input  wire logic       tx_en_i,
    input  wire logic [3:0] txd_i,
    output logic            tx_nibble_take_o,
    output logic            tx_nrzi_o,
    output logic            tx_mlt_pos_o,
    output logic            tx_mlt_neg_o,
    input  wire logic       rx_mlt_pos_i,
    input  wire logic       rx_mlt_neg_i,
    input  wire logic       rx_energy_i,
    output logic            rx_nrz_bit_o,
    output logic            rx_nrz_valid_o,
    output logic [4:0]      rx_symbol_o,
    output logic            rx_symbol_valid_o,
    output logic            rx_signal_detect_o
);

    // ==================================================================
    // Bit-rate enable
    localparam int DIV_W = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);

    logic [DIV_W-1:0] div_ff;
    logic             bit_en;

    assign bit_en = (div_ff == DIV_LAST);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_ff <= '0;
        end else if (bit_en) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + DIV_W'(1);
        end
    end

    // ==================================================================
    // Pin synchronisers
    logic [4:0] straps_meta_ff;
    logic [4:0] straps_sync_ff;
    logic [2:0] pins_meta_ff;
    logic [2:0] pins_sync_ff;
    logic       bypass_s;
    logic       energy_s;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            straps_meta_ff <= '0;
            straps_sync_ff <= '0;
            pins_meta_ff   <= '0;
            pins_sync_ff   <= '0;
        end else begin
            straps_meta_ff <= phy_address_straps_i;
            straps_sync_ff <= straps_meta_ff;
            pins_meta_ff   <= {scramble_bypass_i, rx_energy_i, 1'b0};
            pins_sync_ff   <= pins_meta_ff;
        end
    end

    assign bypass_s = pins_sync_ff[2];
    assign energy_s = pins_sync_ff[1];

    // ==================================================================
    // Seed load
    // Straps are sampled only once the synchroniser has filled after reset.
    logic [1:0] seed_cnt_ff;
    logic       seed_load;
    logic [fepcs_pkg::LFSR_LEN-1:0] seed;

    assign seed_load = (seed_cnt_ff == fepcs_pkg::SEED_WAIT - 2'h1);
    assign seed = {straps_sync_ff[4:1], fepcs_pkg::SEED_LOW};

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seed_cnt_ff <= '0;
        end else if (seed_cnt_ff != fepcs_pkg::SEED_WAIT) begin
            seed_cnt_ff <= seed_cnt_ff + 2'h1;
        end
    end

    // ==================================================================
    // Code-group encoder
    fepcs_pkg::fepcs_tx_state_type tx_state_ff;
    fepcs_pkg::fepcs_tx_state_type nxt_tx_state;
    logic [4:0] tx_shift_ff;
    logic [4:0] nxt_cg;
    logic [2:0] tx_bit_ff;
    logic       cg_load;
    logic       take;

    assign cg_load = bit_en && (tx_bit_ff == fepcs_pkg::BIT_LAST);

    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_cg       = fepcs_pkg::CG_IDLE;
        take         = 1'b0;
        unique case (tx_state_ff)
            fepcs_pkg::TX_IDLE, fepcs_pkg::TX_R: begin
                if (tx_en_i) begin
                    nxt_tx_state = fepcs_pkg::TX_J;
                    nxt_cg       = fepcs_pkg::CG_J;
                    take         = 1'b1;
                end else begin
                    nxt_tx_state = fepcs_pkg::TX_IDLE;
                    nxt_cg       = fepcs_pkg::CG_IDLE;
                end
            end
            fepcs_pkg::TX_J: begin
                nxt_tx_state = fepcs_pkg::TX_K;
                nxt_cg       = fepcs_pkg::CG_K;
                take         = 1'b1;
            end
            fepcs_pkg::TX_K, fepcs_pkg::TX_DATA: begin
                if (tx_en_i) begin
                    nxt_tx_state = fepcs_pkg::TX_DATA;
                    nxt_cg       = fepcs_pkg::enc_4b5b(txd_i);
                    take         = 1'b1;
                end else begin
                    nxt_tx_state = fepcs_pkg::TX_T;
                    nxt_cg       = fepcs_pkg::CG_T;
                end
            end
            fepcs_pkg::TX_T: begin
                nxt_tx_state = fepcs_pkg::TX_R;
                nxt_cg       = fepcs_pkg::CG_R;
            end
            default: begin
                nxt_tx_state = fepcs_pkg::TX_IDLE;
                nxt_cg       = fepcs_pkg::CG_IDLE;
            end
        endcase
    end

    assign tx_nibble_take_o = cg_load && take;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_state_ff <= fepcs_pkg::TX_IDLE;
        end else if (cg_load) begin
            tx_state_ff <= nxt_tx_state;
        end
    end

    // Code-groups leave most significant bit first.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_bit_ff   <= '0;
            tx_shift_ff <= fepcs_pkg::CG_IDLE;
        end else if (cg_load) begin
            tx_bit_ff   <= '0;
            tx_shift_ff <= nxt_cg;
        end else if (bit_en) begin
            tx_bit_ff   <= tx_bit_ff + 3'h1;
            tx_shift_ff <= {tx_shift_ff[3:0], 1'b0};
        end
    end

    // ==================================================================
    // Scrambler, NRZI and MLT-3
    logic       key;
    logic       scr_bit;
    logic       tx_nrzi_ff;
    logic [1:0] tx_phase_ff;
    logic [1:0] nxt_tx_phase;
    logic       tx_pos_ff;
    logic       tx_neg_ff;

    fepcs_scrambler u_scrambler (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .step_i      (bit_en),
        .seed_load_i (seed_load),
        .seed_i      (seed),
        .key_o       (key)
    );

    assign scr_bit = bypass_s ? tx_shift_ff[4]
                              : (tx_shift_ff[4] ^ key);

    // The phase walks 0, +, 0, - so that every second one lands on a drive
    // output, alternating between them; there is no binary drive mode.
    assign nxt_tx_phase = tx_phase_ff + {1'b0, scr_bit};

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_nrzi_ff  <= 1'b0;
            tx_phase_ff <= '0;
            tx_pos_ff   <= 1'b0;
            tx_neg_ff   <= 1'b0;
        end else if (bit_en) begin
            tx_nrzi_ff  <= tx_nrzi_ff ^ scr_bit;
            tx_phase_ff <= nxt_tx_phase;
            tx_pos_ff   <= (nxt_tx_phase == fepcs_pkg::PH_POS);
            tx_neg_ff   <= (nxt_tx_phase == fepcs_pkg::PH_NEG);
        end
    end

    assign tx_nrzi_o    = tx_nrzi_ff;
    assign tx_mlt_pos_o = tx_pos_ff;
    assign tx_mlt_neg_o = tx_neg_ff;

    // ==================================================================
    // Receive MLT-3 to NRZI to NRZ
    logic [1:0] rx_level;
    logic [1:0] rx_level_prev_ff;
    logic       rx_change;
    logic       rx_nrzi_ff;
    logic       rx_nrzi_prev_ff;
    logic       rx_nrz_ff;
    logic       rx_step_ff;

    // Both drive levels at once is not a legal symbol; it reads as zero.
    assign rx_level = (rx_mlt_pos_i && !rx_mlt_neg_i) ? fepcs_pkg::LVL_POS :
                      (rx_mlt_neg_i && !rx_mlt_pos_i) ? fepcs_pkg::LVL_NEG :
                                                        fepcs_pkg::LVL_ZERO;
    assign rx_change = (rx_level != rx_level_prev_ff);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_level_prev_ff <= fepcs_pkg::LVL_ZERO;
            rx_nrzi_ff       <= 1'b0;
        end else if (bit_en) begin
            rx_level_prev_ff <= rx_level;
            rx_nrzi_ff       <= rx_nrzi_ff ^ rx_change;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_nrzi_prev_ff <= 1'b0;
            rx_nrz_ff       <= 1'b0;
            rx_step_ff      <= 1'b0;
        end else begin
            rx_step_ff <= bit_en;
            if (rx_step_ff) begin
                rx_nrzi_prev_ff <= rx_nrzi_ff;
                rx_nrz_ff       <= rx_nrzi_ff ^ rx_nrzi_prev_ff;
            end
        end
    end

    logic rx_nrz_valid_ff;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_nrz_valid_ff <= 1'b0;
        end else begin
            rx_nrz_valid_ff <= rx_step_ff;
        end
    end

    assign rx_nrz_bit_o   = rx_nrz_ff;
    assign rx_nrz_valid_o = rx_nrz_valid_ff;

    // ==================================================================
    // Serial to parallel
    // Symbols are unaligned; alignment on J/K happens further on.
    logic [3:0] rx_shift_ff;
    logic [2:0] rx_bit_ff;
    logic [4:0] rx_symbol_ff;
    logic       rx_symbol_valid_ff;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_shift_ff        <= '0;
            rx_bit_ff          <= '0;
            rx_symbol_ff       <= '0;
            rx_symbol_valid_ff <= 1'b0;
        end else begin
            rx_symbol_valid_ff <= 1'b0;
            if (rx_nrz_valid_ff) begin
                rx_shift_ff <= {rx_shift_ff[2:0], rx_nrz_ff};
                if (rx_bit_ff == fepcs_pkg::BIT_LAST) begin
                    rx_bit_ff          <= '0;
                    rx_symbol_ff       <= {rx_shift_ff, rx_nrz_ff};
                    rx_symbol_valid_ff <= 1'b1;
                end else begin
                    rx_bit_ff <= rx_bit_ff + 3'h1;
                end
            end
        end
    end

    assign rx_symbol_o       = rx_symbol_ff;
    assign rx_symbol_valid_o = rx_symbol_valid_ff;

    // ==================================================================
    // Signal detect
    // A lone link pulse or pulse burst is followed by a long quiet gap,
    // which clears the activity count long before it can qualify.
    logic [5:0]  sd_quiet_ff;
    logic [11:0] sd_active_ff;
    logic        sd_ff;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sd_quiet_ff  <= '0;
            sd_active_ff <= '0;
        end else if (bit_en) begin
            if (rx_change) begin
                sd_quiet_ff <= '0;
            end else if (sd_quiet_ff != fepcs_pkg::SD_QUIET_MAX) begin
                sd_quiet_ff <= sd_quiet_ff + 6'h1;
            end
            if (!energy_s || sd_quiet_ff == fepcs_pkg::SD_QUIET_MAX) begin
                sd_active_ff <= '0;
            end else if (sd_active_ff != fepcs_pkg::SD_ON_BITS) begin
                sd_active_ff <= sd_active_ff + 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sd_ff <= 1'b0;
        end else begin
            sd_ff <= energy_s &&
                     (sd_active_ff == fepcs_pkg::SD_ON_BITS);
        end
    end

    assign rx_signal_detect_o = sd_ff;

endmodule

// ==== fepcs_pkg.sv ====
// Constants, code-groups and the 4B/5B mapping of the 100 Mb/s line coder.
package fepcs_pkg;

    // ==================================================================
    // Code-groups
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J    = 5'h18;
    localparam logic [4:0] CG_K    = 5'h11;
    localparam logic [4:0] CG_T    = 5'h0D;
    localparam logic [4:0] CG_R    = 5'h07;

    // ==================================================================
    // Symbol framing
    localparam int         CG_BITS  = 5;
    localparam logic [2:0] BIT_LAST = 3'h4;

    // ==================================================================
    // Scrambler
    localparam int          LFSR_LEN     = 11;
    localparam int          LFSR_TAP_HI  = 10;
    localparam int          LFSR_TAP_LO  = 8;
    localparam logic [6:0]  SEED_LOW     = 7'h2B;
    localparam logic [1:0]  SEED_WAIT    = 2'h3;

    // ==================================================================
    // Signal detect, counted in bit times
    localparam logic [5:0]  SD_QUIET_MAX = 6'h20;
    localparam logic [11:0] SD_ON_BITS   = 12'h3E8;

    // ==================================================================
    // MLT-3 levels and transmit phases
    localparam logic [1:0] LVL_ZERO = 2'h0;
    localparam logic [1:0] LVL_POS  = 2'h1;
    localparam logic [1:0] LVL_NEG  = 2'h2;
    localparam logic [1:0] PH_POS   = 2'h1;
    localparam logic [1:0] PH_NEG   = 2'h3;

    // ==================================================================
    // Transmit encoder states
    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_J    = 6'h02,
        TX_K    = 6'h04,
        TX_DATA = 6'h08,
        TX_T    = 6'h10,
        TX_R    = 6'h20
    } fepcs_tx_state_type;

    // ==================================================================
    // Data nibble to code-group
    function automatic logic [4:0] enc_4b5b(input logic [3:0] nib);
        logic [4:0] cg;
        cg = 5'h1E;
        unique case (nib)
            4'h0: cg = 5'h1E;
            4'h1: cg = 5'h09;
            4'h2: cg = 5'h14;
            4'h3: cg = 5'h15;
            4'h4: cg = 5'h0A;
            4'h5: cg = 5'h0B;
            4'h6: cg = 5'h0E;
            4'h7: cg = 5'h0F;
            4'h8: cg = 5'h12;
            4'h9: cg = 5'h13;
            4'hA: cg = 5'h16;
            4'hB: cg = 5'h17;
            4'hC: cg = 5'h1A;
            4'hD: cg = 5'h1B;
            4'hE: cg = 5'h1C;
            4'hF: cg = 5'h1D;
        endcase
        return cg;
    endfunction

endpackage

// ==== fepcs_scrambler.sv ====
// Closed-loop 11-bit scrambler key generator with seed load.
`timescale 1ns/10ps
module fepcs_scrambler (
    input  wire logic                          ref_clk_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          step_i,
    input  wire logic                          seed_load_i,
    input  wire logic [fepcs_pkg::LFSR_LEN-1:0] seed_i,
    output logic                               key_o
);

    // ==================================================================
    // Shift register
    logic [fepcs_pkg::LFSR_LEN-1:0] lfsr_ff;
    logic                           fb;

    // x^11 + x^9 + 1, one step per transmitted bit.
    assign fb = lfsr_ff[fepcs_pkg::LFSR_TAP_HI] ^
                lfsr_ff[fepcs_pkg::LFSR_TAP_LO];

    // All ones keeps the register out of the stuck all-zero state.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lfsr_ff <= '1;
        end else if (seed_load_i) begin
            lfsr_ff <= seed_i;
        end else if (step_i) begin
            lfsr_ff <= {lfsr_ff[fepcs_pkg::LFSR_LEN-2:0], fb};
        end
    end

    assign key_o = lfsr_ff[0];

endmodule

// ==== fepcs_line_coder_checker.sv ====
// Concurrent assertions on the ports of the 100 Mb/s line coder.
`timescale 1ns/10ps
module fepcs_line_coder_checker #(
    parameter int BIT_DIV = 1
) (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    input  wire logic tx_nibble_take_o,
    input  wire logic tx_mlt_pos_o,
    input  wire logic tx_mlt_neg_o,
    input  wire logic rx_mlt_pos_i,
    input  wire logic rx_mlt_neg_i,
    input  wire logic rx_energy_i,
    input  wire logic rx_symbol_valid_o,
    input  wire logic rx_signal_detect_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    // ==================================================================
    // Helper state
    logic [11:0] energy_cnt_ff;
    logic [5:0]  quiet_cnt_ff;
    logic [1:0]  rx_lvl_ff;
    logic [1:0]  rx_lvl;
    logic        last_neg_ff;

    assign rx_lvl = {rx_mlt_neg_i & ~rx_mlt_pos_i,
                     rx_mlt_pos_i & ~rx_mlt_neg_i};

    // Counts raw energy so a rise of detect can be judged by its history.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            energy_cnt_ff <= 12'h000;
        end else if (!rx_energy_i) begin
            energy_cnt_ff <= 12'h000;
        end else if (energy_cnt_ff != 12'hFFF) begin
            energy_cnt_ff <= energy_cnt_ff + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_lvl_ff    <= 2'h0;
            quiet_cnt_ff <= 6'h00;
        end else begin
            rx_lvl_ff <= rx_lvl;
            if (rx_lvl != rx_lvl_ff) begin
                quiet_cnt_ff <= 6'h00;
            end else if (quiet_cnt_ff != 6'h3F) begin
                quiet_cnt_ff <= quiet_cnt_ff + 6'h01;
            end
        end
    end

    // The first excursion after reset is positive, so start as if negative.
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_neg_ff <= 1'b1;
        end else if (tx_mlt_neg_o) begin
            last_neg_ff <= 1'b1;
        end else if (tx_mlt_pos_o) begin
            last_neg_ff <= 1'b0;
        end
    end

    // ==================================================================
    // Assertions
    AST_MLT_EXCL: assert property (!(tx_mlt_pos_o && tx_mlt_neg_o))
        else $error("both drive levels high");
    AST_POS_ALT: assert property ($rose(tx_mlt_pos_o) |-> last_neg_ff)
        else $error("two positive excursions in a row");
    AST_NEG_ALT: assert property ($rose(tx_mlt_neg_o) |-> !last_neg_ff)
        else $error("two negative excursions in a row");
    AST_VIA_ZERO: assert property (tx_mlt_pos_o |=> !tx_mlt_neg_o)
        else $error("level jumped past zero");
    AST_TAKE_GAP: assert property (tx_nibble_take_o |=> !tx_nibble_take_o [*4])
        else $error("nibbles taken closer than one code-group");
    AST_SYM_GAP: assert property (rx_symbol_valid_o |=>
        !rx_symbol_valid_o [*4] ##1 rx_symbol_valid_o)
        else $error("symbol not every five bits");
    AST_SD_NO_ENERGY: assert property (!rx_energy_i [*6] |->
        !rx_signal_detect_o)
        else $error("detect high without energy");
    AST_SD_DWELL: assert property ($rose(rx_signal_detect_o) |->
        energy_cnt_ff >= fepcs_pkg::SD_ON_BITS)
        else $error("detect rose too early");
    AST_SD_QUIET: assert property (quiet_cnt_ff >= 6'h28 |->
        !rx_signal_detect_o)
        else $error("detect high on quiet line");

    COV_TAKE: cover property (tx_nibble_take_o ##5 tx_nibble_take_o);
    COV_SD: cover property ($rose(rx_signal_detect_o));
    COV_SD_OFF: cover property ($fell(rx_signal_detect_o));
endmodule

bind fepcs_line_coder fepcs_line_coder_checker #(
    .BIT_DIV(BIT_DIV)
) fepcs_line_coder_checker_inst (
    .ref_clk_i          (ref_clk_i),
    .reset_n_i          (reset_n_i),
    .tx_nibble_take_o   (tx_nibble_take_o),
    .tx_mlt_pos_o       (tx_mlt_pos_o),
    .tx_mlt_neg_o       (tx_mlt_neg_o),
    .rx_mlt_pos_i       (rx_mlt_pos_i),
    .rx_mlt_neg_i       (rx_mlt_neg_i),
    .rx_energy_i        (rx_energy_i),
    .rx_symbol_valid_o  (rx_symbol_valid_o),
    .rx_signal_detect_o (rx_signal_detect_o)
);

// ==== fepcs_mac_model.sv ====
// MAC model that feeds queued nibbles over the transmit interface.
`timescale 1ns/10ps
module fepcs_mac_model (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       tx_nibble_take_i,
    output logic            tx_en_o,
    output logic [3:0]      txd_o
);
    logic [3:0] frame_q[$];

    task automatic queue_nibble(input logic [3:0] nib);
        frame_q.push_back(nib);
    endtask

    // The nibble is held until taken; with no frame the data lines wander,
    // so a coder that samples them outside a take cycle shows it.
    initial begin
        tx_en_o = 1'b0;
        txd_o   = 4'h0;
        forever begin
            @(posedge ref_clk_i);
            if (!reset_n_i) begin
                frame_q.delete();
            end else if (tx_nibble_take_i && tx_en_o) begin
                void'(frame_q.pop_front());
            end
            #1;
            if (frame_q.size() > 0) begin
                tx_en_o = 1'b1;
                txd_o   = frame_q[0];
            end else begin
                tx_en_o = 1'b0;
                txd_o   = ~txd_o;
            end
        end
    end
endmodule

// ==== fepcs_line_coder_tb_top.sv ====
// Self-checking testbench for the 100 Mb/s line coder.
`timescale 1ns/10ps
module fepcs_line_coder_tb_top;
    localparam logic [4:0] DATA_CG [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
        5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
        5'h1A, 5'h1B, 5'h1C, 5'h1D};

    logic       clk;
    logic       reset_n;
    logic [4:0] straps;
    logic       bypass;
    logic       tx_en;
    logic [3:0] txd;
    logic       take;
    logic       pos;
    logic       neg;
    logic       loop_en;
    logic       drv_pos;
    logic       energy;
    logic       nrz_bit;
    logic       nrz_valid;
    logic [4:0] symbol;
    logic       sym_valid;
    logic       sd;
    int         fail_count;
    int         checks;
    logic       bits[$];
    logic       exp_bits[$];
    logic       ref_bits[$];

    fepcs_line_coder fepcs_line_coder_inst (
        .ref_clk_i            (clk),
        .reset_n_i            (reset_n),
        .phy_address_straps_i (straps),
        .scramble_bypass_i    (bypass),
        .tx_en_i              (tx_en),
        .txd_i                (txd),
        .tx_nibble_take_o     (take),
        .tx_nrzi_o            (),
        .tx_mlt_pos_o         (pos),
        .tx_mlt_neg_o         (neg),
        .rx_mlt_pos_i         (loop_en ? pos : drv_pos),
        .rx_mlt_neg_i         (loop_en ? neg : 1'b0),
        .rx_energy_i          (energy),
        .rx_nrz_bit_o         (nrz_bit),
        .rx_nrz_valid_o       (nrz_valid),
        .rx_symbol_o          (symbol),
        .rx_symbol_valid_o    (sym_valid),
        .rx_signal_detect_o   (sd)
    );

    fepcs_mac_model fepcs_mac_model_inst (
        .ref_clk_i        (clk),
        .reset_n_i        (reset_n),
        .tx_nibble_take_i (take),
        .tx_en_o          (tx_en),
        .txd_o            (txd)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input bit ok, input string msg);
        checks++;
        if (!ok) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset();
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
    endtask

    // Loopback gives the recovered bit stream; symbols are judged on the way.
    task automatic capture(input int n);
        bits.delete();
        while (bits.size() < n) begin
            @(posedge clk);
            #1;
            if (sym_valid && bits.size() >= 5) begin
                chk(symbol === {bits[$-4], bits[$-3], bits[$-2],
                    bits[$-1], bits[$]}, "symbol differs from bits");
            end
            if (nrz_valid) begin
                bits.push_back(nrz_bit);
            end
        end
    endtask

    function automatic bit found_expected();
        bit hit;
        for (int s = 0; s + exp_bits.size() <= bits.size(); s++) begin
            hit = 1'b1;
            foreach (exp_bits[i]) begin
                if (bits[s + i] !== exp_bits[i]) begin
                    hit = 1'b0;
                end
            end
            if (hit) begin
                return 1'b1;
            end
        end
        return 1'b0;
    endfunction

    task automatic add_cg(input logic [4:0] cg);
        for (int i = 4; i >= 0; i--) begin
            exp_bits.push_back(cg[i]);
        end
    endtask

    // Sends nibbles unscrambled and looks for the framed code-groups.
    task automatic frame_case(input logic [3:0] nibs[$], input int full);
        exp_bits.delete();
        add_cg(fepcs_pkg::CG_IDLE);
        add_cg(fepcs_pkg::CG_J);
        add_cg(fepcs_pkg::CG_K);
        for (int i = 2; i < nibs.size() && full != 0; i++) begin
            add_cg(DATA_CG[nibs[i]]);
        end
        add_cg(fepcs_pkg::CG_T);
        add_cg(fepcs_pkg::CG_R);
        add_cg(fepcs_pkg::CG_IDLE);
        foreach (nibs[i]) begin
            fepcs_mac_model_inst.queue_nibble(nibs[i]);
        end
        capture(200);
        chk(found_expected(), "framed code-groups not seen");
    endtask

    task automatic test_frames();
        bypass = 1'b1;
        loop_en = 1'b1;
        do_reset();
        repeat (20) @(posedge clk);
        frame_case('{4'h5, 4'h5, 4'h5, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
            4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE,
            4'hF}, 1);
        // Enable drops while J is out: K must still follow before T.
        frame_case('{4'h5}, 0);
    endtask

    task automatic idle_run(input logic [4:0] s);
        straps = s;
        do_reset();
        capture(200);
    endtask

    // Scrambled IDLE: recovered bit m is ~(b[m-11] ^ b[m-9]).
    task automatic test_scrambler();
        int bad;
        int ones;
        bypass = 1'b0;
        idle_run(5'h1E);
        bad = 0;
        ones = 0;
        for (int m = 60; m < bits.size(); m++) begin
            bad += int'(bits[m] !== ~(bits[m-11] ^ bits[m-9]));
            ones += int'(bits[m] === 1'b0);
        end
        chk(bad == 0, "key breaks recurrence");
        chk(ones > 10, "stream not scrambled");
        ref_bits = bits;
        idle_run(5'h1F);
        chk(bits == ref_bits, "strap bit 0 changed seed");
        idle_run(5'h02);
        chk(bits != ref_bits, "straps gave same seed");
    endtask

    task automatic test_signal_detect();
        bit seen;
        seen = 1'b0;
        loop_en = 1'b0;
        for (int p = 0; p < 16; p++) begin
            drv_pos = 1'b1;
            @(posedge clk);
            #1 drv_pos = 1'b0;
            repeat (124) begin
                @(posedge clk);
                seen |= (sd !== 1'b0);
            end
        end
        chk(!seen, "detect on link pulses");
        #1 loop_en = 1'b1;
        repeat (1100) @(posedge clk);
        chk(sd === 1'b1, "detect missing on data");
        #1 energy = 1'b0;
        repeat (8) @(posedge clk);
        chk(sd === 1'b0, "detect held without energy");
    endtask

    initial begin
        reset_n = 1'b0;
        straps = 5'h00;
        bypass = 1'b0;
        loop_en = 1'b1;
        drv_pos = 1'b0;
        energy = 1'b1;
        fail_count = 0;
        checks = 0;
        test_frames();
        test_scrambler();
        test_signal_detect();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        $display("unexpected at %0t: run timed out", $time);
        summarize();
    end
endmodule
